// >>> rtl/tsc_pkg.sv
// shared constants of the temperature sensor conversion controller
// assumes a 10 MHz system clock and a slow host serial clock
package tsc_pkg;
   localparam int CLK_MHZ = 10;
   localparam int CONV_TIME_US = 140000;
   localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
   localparam int CONV_CNT_W = 24;
   localparam int TEMP_W = 11;
   localparam int WORD_W = 16;
   localparam int TX_BITS = 16;
   localparam int TX_DRIVEN = 14;
   localparam int RX_START = 16;
   localparam int FRAME_BITS = 32;
   localparam int CMD_W = 8;
   localparam logic [2:0] TEMP_FILL = 3'h7;
   localparam logic [1:0] TAIL_FILL = 2'h0;
   localparam logic [CMD_W-1:0] CMD_RESET = 8'h00;
   // identification word: value is arbitrary
   localparam logic [WORD_W-1:0] ID_DEFAULT = 16'h5a00;
   localparam logic [TEMP_W-1:0] TEMP_RESET = 11'h000;
endpackage

// >>> rtl/tsc_conv_if.sv
// link between the serial controller and the conversion sequencer
// assumes both ends run on sys_clk
`timescale 1ns/1ps
interface tsc_conv_if;
   logic start;
   logic shutdown;
   logic busy;
   logic done;
   logic result_ok;
   logic [10:0] result;
   modport ctrl (output start, output shutdown, input busy, input done, input result_ok, input result);
   modport conv (input start, input shutdown, output busy, output done, output result_ok, output result);
endinterface

// >>> rtl/tsc_conv.sv
// conversion sequencer: timed conversions, done pulse, result latch
// assumes temp_code comes from the analog front end on sys_clk
`timescale 1ns/1ps
module tsc_conv
   import tsc_pkg::*;
#(
   parameter int CONV_LEN = CONV_CYCLES
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [TEMP_W-1:0] temp_code,
   tsc_conv_if.conv cif
);
   typedef struct packed {
      logic busy;
      logic done;
      logic result_ok;
      logic [CONV_CNT_W-1:0] cnt;
      logic [TEMP_W-1:0] result;
   } tsc_conv_s;

   tsc_conv_s st;
   tsc_conv_s next_st;
   localparam logic [CONV_CNT_W-1:0] LAST = CONV_CNT_W'(CONV_LEN - 1);

   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      if (st.busy) begin
         // serial traffic has no path in here, so a conversion always finishes
         if (st.cnt == LAST) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
            next_st.result = temp_code;
            next_st.result_ok = 1'b1;
         end else begin
            next_st.cnt = st.cnt + 1'b1;
         end
      end else if (cif.start || !cif.shutdown) begin
         next_st.busy = 1'b1;
         next_st.cnt = '0;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st <= '{busy: 1'b0, done: 1'b0, result_ok: 1'b0, cnt: '0, result: TEMP_RESET};
      end else begin
         st <= next_st;
      end
   end

   assign cif.busy = st.busy;
   assign cif.done = st.done;
   assign cif.result_ok = st.result_ok;
   assign cif.result = st.result;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   conv_runs_a: assert property (st.busy && st.cnt != LAST |=> st.busy && st.cnt == $past(st.cnt) + 1'b1)
      else $error("conversion interrupted before its last cycle");
   done_latch_a: assert property (st.busy && st.cnt == LAST |=> st.done && st.result == $past(temp_code))
      else $error("done pulse or result latch missing at conversion end");
endmodule

// >>> rtl/tsc_ctrl.sv
// serial readout controller of the temperature sensor
// assumes host drives cs_n and serial_bus_clock asynchronously; sio pin resolved outside
// Summary of operation
// - a read is accepted any time and returns the last completed result, or the identification word in shutdown.
// - a running conversion always completes; serial activity never aborts it.
// - at end of read, hold register reloads and a fresh conversion starts unless one is already running.
// - after reset the block is in continuous conversion, not shutdown.
// - data before the first completed conversion is invalid; temp_valid flags it.
// - power-up reset clears every internal register to its default.
// - a read-only identification word is readable over the serial link.
// - frame is 32 clocks: 16 out on falling edges, 16 in on rising.
// - last eight received bits all ones enter shutdown, else leave it; a read cut before the receive phase keeps the mode.
// - output is 11-bit result, then three ones, then two floating bits.
// - in shutdown every read shifts out the identification word.
`timescale 1ns/1ps
module tsc_ctrl
   import tsc_pkg::*;
#(
   parameter int CONV_LEN = CONV_CYCLES,
   parameter logic [WORD_W-1:0] ID_WORD = ID_DEFAULT
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic cs_n,
   input wire logic serial_bus_clock,
   input wire logic sio_in,
   input wire logic [TEMP_W-1:0] temp_code,
   output logic sio_out,
   output logic sio_oe_n,
   output logic temp_valid,
   output logic shutdown_mode
);
   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic bclk_s1;
      logic bclk_s2;
      logic sd_s1;
      logic sd_s2;
      logic cs_prev;
      logic bclk_prev;
      logic active;
      logic [4:0] fcnt;
      logic [5:0] rcnt;
      logic [WORD_W-1:0] shreg;
      logic [CMD_W-1:0] rxsh;
      logic shutdown;
      logic valid;
      logic [TEMP_W-1:0] hold;
      logic sdo;
      logic oe_n;
      logic start;
   } tsc_ctrl_s;

   tsc_ctrl_s st;
   tsc_ctrl_s next_st;
   tsc_conv_if cif ();

   tsc_conv #(.CONV_LEN(CONV_LEN)) u_conv (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .temp_code(temp_code),
      .cif(cif)
   );

   function automatic logic [WORD_W-1:0] tx_word(input logic sd, input logic [TEMP_W-1:0] t);
      tx_word = sd ? ID_WORD : {t, TEMP_FILL, TAIL_FILL};
   endfunction

   function automatic logic edge_fall(input logic was, input logic cur);
      edge_fall = was && !cur;
   endfunction

   function automatic logic edge_rise(input logic was, input logic cur);
      edge_rise = !was && cur;
   endfunction

   logic cs_fall;
   logic cs_rise;
   logic bclk_fall;
   logic bclk_rise;
   logic [TEMP_W-1:0] latest;
   logic [WORD_W-1:0] word;

   always_comb begin
      cs_fall = edge_fall(st.cs_prev, st.cs_s2);
      cs_rise = edge_rise(st.cs_prev, st.cs_s2);
      bclk_fall = edge_fall(st.bclk_prev, st.bclk_s2);
      bclk_rise = edge_rise(st.bclk_prev, st.bclk_s2);
      // a result completing on the opening edge goes out at once instead of one read late
      latest = (cif.done && !st.active) ? cif.result : st.hold;
      word = tx_word(st.shutdown, latest);
      next_st = st;
      next_st.cs_s1 = cs_n;
      next_st.cs_s2 = st.cs_s1;
      next_st.bclk_s1 = serial_bus_clock;
      next_st.bclk_s2 = st.bclk_s1;
      next_st.sd_s1 = sio_in;
      next_st.sd_s2 = st.sd_s1;
      next_st.cs_prev = st.cs_s2;
      next_st.bclk_prev = st.bclk_s2;
      next_st.start = 1'b0;
      // hold follows each finished conversion except during a read, so the word stays stable
      if (cif.done && !st.active) begin
         next_st.hold = cif.result;
         next_st.valid = 1'b1;
      end
      if (cs_fall) begin
         next_st.active = 1'b1;
         next_st.fcnt = '0;
         next_st.rcnt = '0;
         next_st.rxsh = CMD_RESET;
         next_st.shreg = word;
         next_st.sdo = word[WORD_W-1];
         next_st.oe_n = 1'b0;
      end else if (st.active && !st.cs_s2) begin
         if (bclk_fall && st.fcnt < 5'(TX_BITS)) begin
            next_st.fcnt = st.fcnt + 1'b1;
            next_st.shreg = {st.shreg[WORD_W-2:0], 1'b0};
            next_st.sdo = st.shreg[WORD_W-2];
            if (st.fcnt + 1'b1 >= 5'(TX_DRIVEN)) begin
               next_st.oe_n = 1'b1;
            end
         end
         if (bclk_rise && st.rcnt < 6'(FRAME_BITS)) begin
            next_st.rcnt = st.rcnt + 1'b1;
            if (st.rcnt >= 6'(RX_START)) begin
               next_st.rxsh = {st.rxsh[CMD_W-2:0], st.sd_s2};
            end
         end
      end else if (cs_rise && st.active) begin
         next_st.active = 1'b0;
         next_st.oe_n = 1'b1;
         if (st.rcnt > 6'(RX_START)) begin
            next_st.shutdown = &st.rxsh;
         end
         next_st.hold = cif.result;
         next_st.valid = cif.result_ok;
         next_st.start = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st <= '{cs_s1: 1'b1, cs_s2: 1'b1, bclk_s1: 1'b0, bclk_s2: 1'b0, sd_s1: 1'b0, sd_s2: 1'b0,
                 cs_prev: 1'b1, bclk_prev: 1'b0, active: 1'b0, fcnt: '0, rcnt: '0, shreg: '0,
                 rxsh: CMD_RESET, shutdown: 1'b0, valid: 1'b0, hold: TEMP_RESET, sdo: 1'b0,
                 oe_n: 1'b1, start: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign cif.start = st.start;
   assign cif.shutdown = st.shutdown;
   assign sio_out = st.sdo;
   assign sio_oe_n = st.oe_n;
   assign temp_valid = st.valid;
   assign shutdown_mode = st.shutdown;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence seq_open;
      st.cs_prev && !st.cs_s2;
   endsequence
   sequence seq_close;
      !st.cs_prev && st.cs_s2 && st.active;
   endsequence

   read_open_a: assert property (seq_open |=> st.active && !st.oe_n && st.fcnt == 5'd0)
      else $error("read not opened on chip select fall");
   temp_format_a: assert property (seq_open ##0 !st.shutdown |=> st.shreg[4:2] == TEMP_FILL)
      else $error("temperature word fill bits wrong");
   id_word_a: assert property (seq_open ##0 st.shutdown |=> st.shreg == ID_WORD)
      else $error("identification word not loaded in shutdown");
   tail_float_a: assert property (st.active && st.fcnt >= 5'(TX_DRIVEN) |-> st.oe_n)
      else $error("data line driven after fourteen bits");
   idle_float_a: assert property (!st.active |-> st.oe_n)
      else $error("data line driven outside a read");
   restart_conv_a: assert property (seq_close |=> st.start ##1 !st.start)
      else $error("no single restart pulse after read");
   shutdown_cmd_a: assert property (seq_close ##0 (st.rcnt > 6'(RX_START)) |=> st.shutdown == $past(&st.rxsh))
      else $error("shutdown not set from last eight bits");
   valid_source_a: assert property (st.valid |-> cif.result_ok)
      else $error("valid flag before first conversion");

   // counters and the receive register move only on edges inside an open read
   sequence seq_bit_fall;
      st.active && !st.cs_s2 && bclk_fall;
   endsequence
   sequence seq_bit_rise;
      st.active && !st.cs_s2 && bclk_rise;
   endsequence
   sequence seq_rx_bit;
      st.active && !st.cs_s2 && bclk_rise && st.rcnt >= 6'(RX_START) && st.rcnt < 6'(FRAME_BITS);
   endsequence
   sequence seq_rx_full;
      st.active && !st.cs_s2 && st.rcnt == 6'(FRAME_BITS);
   endsequence

   first_bit_a: assert property (seq_open |=> st.sdo == st.shreg[WORD_W-1])
      else $error("first data bit not on the line at read start");
   shift_step_a: assert property (seq_bit_fall ##0 st.fcnt < 5'(TX_BITS) |=> st.fcnt == $past(st.fcnt) + 1'b1)
      else $error("bit counter not advanced on serial clock fall");
   shift_data_a: assert property (seq_bit_fall ##0 st.fcnt < 5'(TX_BITS) |=> st.sdo == $past(st.shreg[WORD_W-2]))
      else $error("next data bit not shifted out on serial clock fall");
   tx_stop_a: assert property (st.active && !st.cs_s2 && st.fcnt == 5'(TX_BITS) |=> st.fcnt == 5'(TX_BITS))
      else $error("transmit phase ran past sixteen bits");
   rx_window_a: assert property (seq_bit_rise ##0 st.rcnt < 6'(RX_START) |=> $stable(st.rxsh))
      else $error("data taken in during the transmit phase");
   rx_shift_a: assert property (seq_rx_bit |=> st.rxsh == {$past(st.rxsh[CMD_W-2:0]), $past(st.sd_s2)})
      else $error("received bit not shifted into the command register");
   rx_stop_a: assert property (seq_rx_full |=> st.rcnt == 6'(FRAME_BITS) && $stable(st.rxsh))
      else $error("receive phase ran past thirty-two clocks");
   idle_still_a: assert property (!st.active && !cs_fall |=> $stable(st.fcnt) && $stable(st.rcnt))
      else $error("serial clock counted outside a read");
   hold_frozen_a: assert property (st.active && !st.cs_s2 |=> $stable(st.hold))
      else $error("held result changed during a read");
   close_reload_a: assert property (seq_close |=> st.hold == $past(cif.result) && st.valid == $past(cif.result_ok))
      else $error("held result not reloaded at read end");
   done_load_a: assert property (cif.done && !st.active |=> st.hold == $past(cif.result) && st.valid)
      else $error("finished conversion not latched while idle");
   valid_keep_a: assert property (st.valid |=> st.valid)
      else $error("valid flag dropped without reset");
   cmd_short_a: assert property (seq_close ##0 st.rcnt <= 6'(RX_START) |=> $stable(st.shutdown))
      else $error("mode changed by a read without a receive phase");
   start_after_read_a: assert property (st.start |-> $past(st.active))
      else $error("restart request without a finished read");
endmodule

// >>> tb/tsc_host.sv
// host model: serial bus master of the sensor's three-wire link
// assumes the bench resolves the data wire and feeds it back on sio
`timescale 1ns/1ps
module tsc_host (
   input wire logic sys_clk,
   input wire logic sio,
   output logic cs_n,
   output logic serial_bus_clock,
   output logic host_d,
   output logic host_oe
);
   initial begin
      cs_n = 1'b1;
      serial_bus_clock = 1'b0;
      host_d = 1'b0;
      host_oe = 1'b0;
   end
   // four cycles per half gives the 800 ns link clock
   task automatic half();
      repeat (4) @(posedge sys_clk);
   endtask
   // link clock stands low between frames
   task automatic frame(input logic [7:0] cmd, output logic [15:0] word);
      word = 16'h0000;
      cs_n <= 1'b0;
      half();
      for (int i = 15; i >= 0; i--) begin
         serial_bus_clock <= 1'b1;
         half();
         // sampled late in the high phase, well after the shift
         word[i] = sio;
         serial_bus_clock <= 1'b0;
         half();
      end
      host_oe <= 1'b1;
      for (int i = 15; i >= 0; i--) begin
         host_d <= (i < 8) ? cmd[i] : 1'b0;
         half();
         serial_bus_clock <= 1'b1;
         half();
         serial_bus_clock <= 1'b0;
      end
      half();
      cs_n <= 1'b1;
      host_oe <= 1'b0;
      half();
      half();
   endtask
   // chip select rises after the given number of transmit clocks, at most sixteen
   task automatic cut_frame(input int clocks, output logic [15:0] word);
      word = 16'h0000;
      cs_n <= 1'b0;
      half();
      for (int i = 15; i >= 16 - clocks; i--) begin
         serial_bus_clock <= 1'b1;
         half();
         word[i] = sio;
         serial_bus_clock <= 1'b0;
         half();
      end
      cs_n <= 1'b1;
      half();
      half();
   endtask
endmodule

// >>> tb/tb_temp_sensor_conversion_ctrl.sv
// self-checking bench of the sensor readout controller
// assumes tsc_host as link master and a shortened conversion
`timescale 1ns/1ps
module tb_temp_sensor_conversion_ctrl;
   import tsc_pkg::*;
   localparam int CONV_SIM = 200;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [TEMP_W-1:0] temp_code = 11'h190;
   logic cs_n, sclk, host_d, host_oe, sio_out, sio_oe_n, temp_valid, shutdown_mode, sio;
   logic sio_last = 1'b0;
   logic [31:0] oe_trace = 32'h0000_0000;
   int num_errors = 0;
   int checked = 0;
   logic [15:0] w;
   logic [7:0] codes [8] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0f, 8'h1f, 8'h3f, 8'h7f};
   // a released wire shows the inverse of its last level
   assign sio = !sio_oe_n ? sio_out : (host_oe ? host_d : ~sio_last);
   always_ff @(posedge sys_clk) sio_last <= sio;
   // drive state of the data pin at each serial clock rise of the last frame
   always_ff @(posedge sclk) oe_trace <= {oe_trace[30:0], sio_oe_n};
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   tsc_ctrl #(.CONV_LEN(CONV_SIM)) uut (.sys_clk(sys_clk), .nrst(nrst), .cs_n(cs_n),
      .serial_bus_clock(sclk), .sio_in(sio), .temp_code(temp_code), .sio_out(sio_out),
      .sio_oe_n(sio_oe_n), .temp_valid(temp_valid), .shutdown_mode(shutdown_mode));
   tsc_host host (.sys_clk(sys_clk), .sio(sio), .cs_n(cs_n), .serial_bus_clock(sclk),
      .host_d(host_d), .host_oe(host_oe));
   task automatic chk_word(input logic [13:0] got, input logic [13:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t word got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t flag got %b exp %b", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      if (num_errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic t_power_up();
      chk_bit(shutdown_mode, 1'b0);
      chk_bit(temp_valid, 1'b0);
      host.frame(8'h00, w);
      chk_word(w[15:2], {TEMP_RESET, TEMP_FILL});
      host.frame(8'h00, w);
      chk_word(w[15:2], {11'h190, TEMP_FILL});
      chk_bit(temp_valid, 1'b1);
      chk_word(oe_trace[31:18], 14'h0000);
      chk_word(oe_trace[17:4], 14'h3fff);
   endtask
   // the conversion ends inside the frame, so its result must wait
   task automatic t_read_in_conv();
      temp_code <= 11'h79c;
      host.frame(8'h00, w);
      chk_word(w[15:2], {11'h190, TEMP_FILL});
      host.frame(8'h00, w);
      chk_word(w[15:2], {11'h79c, TEMP_FILL});
   endtask
   task automatic t_shutdown();
      for (int i = 0; i < 8; i++) begin
         host.frame(8'hff, w);
         chk_bit(shutdown_mode, 1'b1);
         host.frame(codes[i], w);
         chk_word(w[15:2], ID_DEFAULT[15:2]);
         chk_bit(shutdown_mode, 1'b0);
      end
      host.frame(8'h00, w);
      chk_word(w[15:2], {11'h79c, TEMP_FILL});
   endtask
   task automatic t_mid_reset();
      host.frame(8'hff, w);
      nrst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk_bit(shutdown_mode, 1'b0);
      chk_bit(temp_valid, 1'b0);
      nrst <= 1'b1;
      @(posedge sys_clk);
      host.frame(8'h00, w);
      chk_word(w[15:2], {TEMP_RESET, TEMP_FILL});
      chk_bit(temp_valid, 1'b1);
   endtask
   // a read cut inside the transmit phase carries no command
   task automatic t_cut_frame();
      host.frame(8'hff, w);
      host.cut_frame(8, w);
      chk_word({w[15:8], 6'h00}, {ID_DEFAULT[15:8], 6'h00});
      chk_bit(shutdown_mode, 1'b1);
      host.frame(8'h00, w);
      chk_word(w[15:2], ID_DEFAULT[15:2]);
      chk_word(oe_trace[31:18], 14'h0000);
      chk_word(oe_trace[17:4], 14'h3fff);
      chk_bit(shutdown_mode, 1'b0);
   endtask
   initial begin
      repeat (100000) @(posedge sys_clk);
      num_errors++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      t_power_up();
      t_read_in_conv();
      t_shutdown();
      t_cut_frame();
      t_mid_reset();
      stop_test();
   end
endmodule
